// ### rtl/swc_pkg.sv
// package for the sleep and wake controller: offsets, fields, resets, timing
package swc_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] OFF_TIMER0_CONFIG   = 8'hB0;  // timer 0 configuration
  localparam logic [7:0] OFF_SLEEP_CONFIG_TWO = 8'h10; // refresh interval field
  localparam logic [7:0] OFF_OSC_CONTROL_ZERO = 8'h11; // refresh disable bit
  localparam logic [7:0] OFF_SLEEP_CMD       = 8'h12;  // sleep command and mode
  localparam logic [7:0] OFF_WAKE_ENABLE     = 8'h13;  // wake source enables
  localparam logic [7:0] OFF_IRQ_STATUS      = 8'h14;  // sticky events, write one to clear
  localparam logic [7:0] OFF_IRQ_MASK        = 8'h15;  // interrupt mask
  localparam logic [7:0] OFF_STATE           = 8'h16;  // live state readback
  localparam logic [7:0] OFF_TIMER0_RELOAD   = 8'h17;  // timer 0 period
  localparam logic [7:0] OFF_SLEEP_TIMER     = 8'h18;  // sleep timer period

  // field positions
  localparam int TIMER0_EN_BIT      = 0;
  localparam int TIMER0_ONESHOT_BIT = 1;
  localparam int REFRESH_OFF_BIT    = 3;
  localparam int SLEEP_GO_BIT       = 0;
  localparam int SLEEP_MODE_LSB     = 1;

  // status bit positions, same layout in the mask
  localparam int EV_TIMER0 = 0;
  localparam int EV_SLPTMR = 1;
  localparam int EV_GPIO   = 2;
  localparam int EV_ANALOG = 3;
  localparam int EV_I2C    = 4;
  localparam int EV_WAKE   = 5;
  localparam int EV_LOCK   = 6;

  // reset values
  localparam logic [7:0] TIMER0_CONFIG_RST = 8'h00;
  localparam logic [1:0] REFRESH_INTERVAL_RST = 2'h0;
  localparam logic [7:0] WAKE_ENABLE_RST   = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST      = 8'h00;
  localparam logic [7:0] TIMER0_RELOAD_RST = 8'hFF;
  localparam logic [7:0] SLEEP_TIMER_RST   = 8'hFF;

  // timing: refresh period and the lost-interrupt window
  localparam int CLK_MHZ         = 50;
  localparam int REFRESH_MS      = 8;
  localparam int REFRESH_CYCLES  = REFRESH_MS * 1000 * CLK_MHZ;
  localparam int LOSS_WINDOW_X10 = 25;  // 2.5 cpu cycles, in tenths
  localparam int LOSS_CYCLES     = LOSS_WINDOW_X10 / 10;  // longest time, rounded down
  localparam int REFRESH_PULSE_CYCLES = 4;  // bandgap on cycles after each refresh cycle

  // sleep modes
  typedef enum logic [1:0] {
    SWC_MODE_DEEP    = 2'h0,
    SWC_MODE_STANDBY = 2'h1,
    SWC_MODE_HOST    = 2'h2
  } swc_mode_t;

  // controller state, gray along run, sleep, waking
  typedef enum logic [1:0] {
    SWC_RUN    = 2'b00,
    SWC_SLEEP  = 2'b01,
    SWC_WAKING = 2'b11,
    SWC_LOCKED = 2'b10
  } swc_state_t;

  // wake source pin group
  typedef struct packed {
    logic gpio;
    logic analog;
    logic i2c_start;
  } swc_wake_pins_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } swc_bus_req_t;

endpackage

// ### rtl/swc_top.sv
// sleep and wake controller: bandgap refresh, wake sources, event status
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none

module swc_top #(
  parameter int REFRESH_CYCLES_P = swc_pkg::REFRESH_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  watchdog_reset,
  input  wire logic                  external_reset_pin,
  input  wire swc_pkg::swc_wake_pins_t wake_pins,
  input  wire swc_pkg::swc_bus_req_t bus_req,
  output logic [7:0]                 rdata,
  output logic                       irq,
  output logic                       sleeping,
  output logic                       bandgap_on,
  output logic                       timer0_irq,
  output logic                       gpio_irq
);

  // reset release synchroniser
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // pin synchronisers, first stage read only by the second
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
    end else begin
      pin_s1 <= {watchdog_reset, external_reset_pin, wake_pins};
      pin_s2 <= pin_s1;
    end
  end
  logic wdog_s;
  logic pin_rst_s;
  logic gpio_s;
  logic analog_s;
  logic i2c_s;
  assign {wdog_s, pin_rst_s, gpio_s, analog_s, i2c_s} = pin_s2;

  // registers
  logic [7:0]        timer0_config;     // enable and one-shot
  logic [1:0]        bandgap_refresh_interval;
  logic              refresh_off;       // oscillator control zero bit
  swc_pkg::swc_mode_t sleep_mode;
  logic [7:0]        wake_enable;
  logic [7:0]        irq_status;
  logic [7:0]        irq_mask;
  logic [7:0]        timer0_reload;
  logic [7:0]        sleep_timer;
  swc_pkg::swc_state_t state;

  // write decode used by several processes
  function automatic logic hit(input swc_pkg::swc_bus_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  logic sleep_cmd;
  assign sleep_cmd = hit(bus_req, swc_pkg::OFF_SLEEP_CMD) && bus_req.wdata[swc_pkg::SLEEP_GO_BIT];

  // timer 0 and sleep timer
  logic [7:0] t0_cnt;
  logic [7:0] st_cnt;
  logic       t0_fire;
  logic       st_fire;
  logic       t0_again;   // pending second entry in one-shot after sleep wake
  assign t0_fire = timer0_config[swc_pkg::TIMER0_EN_BIT] && (t0_cnt == 8'h00);
  assign st_fire = wake_enable[swc_pkg::EV_SLPTMR] && (st_cnt == 8'h00);

  // timer 0 writes; one-shot stops itself after firing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer0_config <= swc_pkg::TIMER0_CONFIG_RST;
    end else if (hit(bus_req, swc_pkg::OFF_TIMER0_CONFIG)) begin
      timer0_config <= bus_req.wdata;
    end else if (t0_fire && timer0_config[swc_pkg::TIMER0_ONESHOT_BIT]) begin
      timer0_config[swc_pkg::TIMER0_EN_BIT] <= 1'b0;
    end
  end

  // timer counters reload on expiry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t0_cnt <= swc_pkg::TIMER0_RELOAD_RST;
      st_cnt <= swc_pkg::SLEEP_TIMER_RST;
    end else begin
      t0_cnt <= (t0_cnt == 8'h00 || !timer0_config[swc_pkg::TIMER0_EN_BIT]) ?
                timer0_reload : t0_cnt - 8'h01;
      st_cnt <= (st_cnt == 8'h00 || !wake_enable[swc_pkg::EV_SLPTMR]) ?
                sleep_timer : st_cnt - 8'h01;
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bandgap_refresh_interval <= swc_pkg::REFRESH_INTERVAL_RST;
      refresh_off   <= 1'b0;
      sleep_mode    <= swc_pkg::SWC_MODE_DEEP;
      wake_enable   <= swc_pkg::WAKE_ENABLE_RST;
      irq_mask      <= swc_pkg::IRQ_MASK_RST;
      timer0_reload <= swc_pkg::TIMER0_RELOAD_RST;
      sleep_timer   <= swc_pkg::SLEEP_TIMER_RST;
    end else begin
      if (hit(bus_req, swc_pkg::OFF_SLEEP_CONFIG_TWO))
        bandgap_refresh_interval <= bus_req.wdata[1:0];
      if (hit(bus_req, swc_pkg::OFF_OSC_CONTROL_ZERO))
        refresh_off <= bus_req.wdata[swc_pkg::REFRESH_OFF_BIT];
      if (sleep_cmd)
        sleep_mode <= swc_pkg::swc_mode_t'(bus_req.wdata[2:1]);
      if (hit(bus_req, swc_pkg::OFF_WAKE_ENABLE))
        wake_enable <= bus_req.wdata;
      if (hit(bus_req, swc_pkg::OFF_IRQ_MASK))
        irq_mask <= bus_req.wdata;
      if (hit(bus_req, swc_pkg::OFF_TIMER0_RELOAD))
        timer0_reload <= bus_req.wdata;
      if (hit(bus_req, swc_pkg::OFF_SLEEP_TIMER))
        sleep_timer <= bus_req.wdata;
    end
  end

  // bandgap refresh timer, only in standby and host wake sleep
  logic [31:0] bg_cnt;
  logic [31:0] bg_period;
  logic        refresh_mode;
  logic        refresh_due;
  assign bg_period = 32'(REFRESH_CYCLES_P) << bandgap_refresh_interval;
  assign refresh_mode = (state == swc_pkg::SWC_SLEEP) && !refresh_off &&
                        (sleep_mode != swc_pkg::SWC_MODE_DEEP);
  assign refresh_due = refresh_mode && (bg_cnt >= bg_period - 32'd1);
  logic [2:0] bg_on_cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bg_cnt    <= 32'd0;
      bg_on_cnt <= 3'd0;
    end else begin
      bg_cnt <= (!refresh_mode || refresh_due) ? 32'd0 : bg_cnt + 32'd1;
      if (refresh_due)
        bg_on_cnt <= 3'(swc_pkg::REFRESH_PULSE_CYCLES);
      else if (bg_on_cnt != 3'd0)
        bg_on_cnt <= bg_on_cnt - 3'd1;
    end
  end

  // wake events; gpio dropped when a timer fires in the same cycle during sleep
  logic ev_t0;
  logic ev_st;
  logic ev_gpio;
  logic ev_an;
  logic ev_i2c;
  logic gpio_d;
  logic an_d;
  logic i2c_d;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_d <= 1'b0;
      an_d   <= 1'b0;
      i2c_d  <= 1'b0;
    end else begin
      gpio_d <= gpio_s;
      an_d   <= analog_s;
      i2c_d  <= i2c_s;
    end
  end
  assign ev_t0   = t0_fire || t0_again;
  assign ev_st   = st_fire;
  assign ev_gpio = gpio_s && !gpio_d && wake_enable[swc_pkg::EV_GPIO] &&
                   !((state == swc_pkg::SWC_SLEEP) && (ev_t0 || ev_st));
  assign ev_an   = analog_s && !an_d && wake_enable[swc_pkg::EV_ANALOG];
  assign ev_i2c  = i2c_s && !i2c_d && wake_enable[swc_pkg::EV_I2C];

  // events in the last cycles before a sleep command are dropped
  logic [7:0] ev_raw;
  logic [1:0] since_sleep;   // cycles since the sleep command
  logic       drop;
  assign ev_raw = {2'b00, 1'b0, ev_i2c, ev_an, ev_gpio, ev_st, ev_t0};
  assign drop = sleep_cmd;
  logic [7:0] ev_hist [swc_pkg::LOSS_CYCLES];  // recent events awaiting posting
  logic [7:0] ev_post;
  assign ev_post = drop ? 8'h00 : ev_hist[swc_pkg::LOSS_CYCLES-1];
  generate
    for (genvar i = 0; i < swc_pkg::LOSS_CYCLES; i++) begin : g_hist
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          ev_hist[i] <= 8'h00;
        else if (drop)
          ev_hist[i] <= 8'h00;
        else
          ev_hist[i] <= (i == 0) ? ev_raw : ev_hist[(i == 0) ? 0 : i-1];
      end
    end
  endgenerate

  // controller state; lock only from a wake out of standby or host sleep with a long interval or refresh off
  logic wake_any;
  logic t0_woke;   // timer 0 was among the sources that ended sleep
  assign wake_any = |ev_raw[4:0];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= swc_pkg::SWC_RUN;
      t0_again    <= 1'b0;
      t0_woke     <= 1'b0;
      since_sleep <= 2'd0;
    end else if (wdog_s || pin_rst_s) begin
      state    <= swc_pkg::SWC_RUN;
      t0_again <= 1'b0;
    end else begin
      t0_again <= 1'b0;
      unique case (state)
        swc_pkg::SWC_RUN: begin
          if (sleep_cmd) state <= swc_pkg::SWC_SLEEP;
          since_sleep <= 2'd0;
        end
        swc_pkg::SWC_SLEEP: begin
          if (since_sleep != 2'd3) since_sleep <= since_sleep + 2'd1;
          if (wake_any) begin
            t0_woke <= ev_raw[swc_pkg::EV_TIMER0];
            if ((bandgap_refresh_interval != 2'h0 || refresh_off) &&
                sleep_mode != swc_pkg::SWC_MODE_DEEP)
              state <= swc_pkg::SWC_LOCKED;
            else
              state <= swc_pkg::SWC_WAKING;
          end
        end
        swc_pkg::SWC_WAKING: begin
          state    <= swc_pkg::SWC_RUN;
          t0_again <= timer0_config[swc_pkg::TIMER0_ONESHOT_BIT] && t0_woke;
        end
        swc_pkg::SWC_LOCKED: state <= swc_pkg::SWC_LOCKED;
      endcase
    end
  end

  // sticky status, set wins over write-one-to-clear
  logic [7:0] ev_set;
  assign ev_set = ev_post |
                  {1'b0, state == swc_pkg::SWC_LOCKED, state == swc_pkg::SWC_WAKING, 5'h00};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      irq_status <= 8'h00;
    else if (hit(bus_req, swc_pkg::OFF_IRQ_STATUS))
      irq_status <= (irq_status & ~bus_req.wdata) | ev_set;
    else
      irq_status <= irq_status | ev_set;
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        swc_pkg::OFF_TIMER0_CONFIG:    rdata <= timer0_config;
        swc_pkg::OFF_SLEEP_CONFIG_TWO: rdata <= {6'h00, bandgap_refresh_interval};
        swc_pkg::OFF_OSC_CONTROL_ZERO: rdata <= {4'h0, refresh_off, 3'h0};
        swc_pkg::OFF_SLEEP_CMD:        rdata <= {5'h00, sleep_mode, 1'b0};
        swc_pkg::OFF_WAKE_ENABLE:      rdata <= wake_enable;
        swc_pkg::OFF_IRQ_STATUS:       rdata <= irq_status;
        swc_pkg::OFF_IRQ_MASK:         rdata <= irq_mask;
        swc_pkg::OFF_STATE:            rdata <= {6'h00, state};
        swc_pkg::OFF_TIMER0_RELOAD:    rdata <= timer0_reload;
        swc_pkg::OFF_SLEEP_TIMER:      rdata <= sleep_timer;
        default:                       rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq        <= 1'b0;
      sleeping   <= 1'b0;
      bandgap_on <= 1'b1;
      timer0_irq <= 1'b0;
      gpio_irq   <= 1'b0;
    end else begin
      irq        <= |(irq_status & irq_mask);
      sleeping   <= (state == swc_pkg::SWC_SLEEP) || (state == swc_pkg::SWC_LOCKED);
      bandgap_on <= (state == swc_pkg::SWC_RUN) || (state == swc_pkg::SWC_WAKING) ||
                    refresh_due || (bg_on_cnt != 3'd0) ||
                    (sleep_mode == swc_pkg::SWC_MODE_DEEP && state == swc_pkg::SWC_SLEEP);
      timer0_irq <= ev_post[swc_pkg::EV_TIMER0];
      gpio_irq   <= ev_post[swc_pkg::EV_GPIO];
    end
  end

endmodule

`default_nettype wire

// ### verification/swc_monitor.sv
// port checker for the sleep and wake controller
`timescale 1ns/100ps
`default_nettype none
module swc_monitor (
  input wire logic                    clk,
  input wire logic                    reset_n,
  input wire logic                    watchdog_reset,
  input wire logic                    external_reset_pin,
  input wire swc_pkg::swc_wake_pins_t wake_pins,
  input wire swc_pkg::swc_bus_req_t   bus_req,
  input wire logic [7:0]              rdata,
  input wire logic                    irq,
  input wire logic                    sleeping,
  input wire logic                    bandgap_on,
  input wire logic                    timer0_irq,
  input wire logic                    gpio_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // sleep command write with the go bit set
  wire logic go_wr = bus_req.wr && bus_req.addr == swc_pkg::OFF_SLEEP_CMD && bus_req.wdata[0];
  // unmapped read address, above the table and not the timer page
  wire logic bad_rd = bus_req.rd && bus_req.addr > 8'h18 && bus_req.addr != 8'hB0;

  a_rdata_only_after: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
    else $error("read data outside its answer cycle");
  a_unmapped_read_zero: assert property (bad_rd |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_sleep_needs_cmd: assert property ($rose(sleeping) |->
    $past(go_wr) || $past(go_wr, 2) || $past(go_wr, 3) || $past(go_wr, 4))
    else $error("sleep entered without a command");
  a_watchdog_exit: assert property ($rose(watchdog_reset) |-> ##[1:8] !sleeping)
    else $error("watchdog did not end sleep or lock");
  a_pin_exit: assert property ($rose(external_reset_pin) |-> ##[1:8] !sleeping)
    else $error("reset pin did not end sleep or lock");
  a_timer0_pulse_one: assert property (timer0_irq |=> !timer0_irq)
    else $error("timer0 event longer than one cycle");
  a_gpio_pulse_one: assert property (gpio_irq |=> !gpio_irq)
    else $error("gpio event longer than one cycle");
  a_irq_fall_cause: assert property ($fell(irq) |->
    $past(bus_req.wr) || $past(bus_req.wr, 2) || $past(bus_req.wr, 3))
    else $error("irq dropped without a register write");
endmodule
`default_nettype wire

// ### verification/swc_host_model.sv
// outside world model: drives the wake pins as a host or sensor would
`timescale 1ns/100ps
`default_nettype none
module swc_host_model (
  input  wire logic                    clk,
  output var  swc_pkg::swc_wake_pins_t wake_pins
);
  initial wake_pins = '0;  // all wake lines idle low
  // level change on the caller's edge, no waiting
  task automatic set(input int idx, input logic val);
    wake_pins[idx] <= val;
  endtask
  // held high long enough to pass the two-flop synchroniser
  task automatic pulse(input int idx);
    @(posedge clk);
    wake_pins[idx] <= 1'b1;
    repeat (4) @(posedge clk);
    wake_pins[idx] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verification/test_swc_top.sv
// self-checking bench for the sleep and wake controller
`timescale 1ns/100ps
`default_nettype none
module test_swc_top;
  localparam int RP = 16;  // short refresh period keeps the run brief
  logic                    clk = 1'b0;
  logic                    reset_n = 1'b0;
  logic                    watchdog_reset = 1'b0;
  logic                    external_reset_pin = 1'b0;
  swc_pkg::swc_wake_pins_t wake_pins;
  swc_pkg::swc_bus_req_t   bus_req = '0;
  logic [7:0]              rdata;
  logic                    irq;
  logic                    sleeping;
  logic                    bandgap_on;
  logic                    timer0_irq;
  logic                    gpio_irq;
  int                      errors = 0;
  int                      n_tests = 0;
  int                      cyc = 0;
  int                      k;
  logic [7:0] ra [6] = '{8'hB0, 8'h13, 8'h15, 8'h17, 8'h18, 8'hF0};  // reset table
  logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
  always #10 clk = ~clk;  // 50 MHz
  swc_top #(.REFRESH_CYCLES_P(RP)) i_dut (.clk(clk), .reset_n(reset_n),
    .watchdog_reset(watchdog_reset), .external_reset_pin(external_reset_pin),
    .wake_pins(wake_pins), .bus_req(bus_req), .rdata(rdata), .irq(irq),
    .sleeping(sleeping), .bandgap_on(bandgap_on), .timer0_irq(timer0_irq),
    .gpio_irq(gpio_irq));
  swc_host_model u_host (.clk(clk), .wake_pins(wake_pins));
  // compare and count
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask
  // one-cycle read strobe, data taken in the answer cycle
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1 chk($sformatf("reg %h", a), exp, rdata);
  endtask
  // bounded wait for the sleep flag
  task automatic wait_sl(input logic e);
    for (k = 0; k < 200 && sleeping !== e; k++) @(posedge clk);
    chk("sleeping", {7'h00, e}, {7'h00, sleeping});
  endtask
  // irq is registered after the register update
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge clk);
    #1 chk("irq", {7'h00, e}, {7'h00, irq});
  endtask
  // count timer0 pulses, gpio pulses or bandgap rises
  task automatic cnt(input int sel, input int cycles, input logic [7:0] exp);
    logic [7:0] n;
    logic       p;
    logic       s;
    n = 8'h00;
    p = 1'b1;  // a bandgap pulse already running is not counted
    repeat (cycles) begin
      @(posedge clk);
      #1;
      s = (sel == 0) ? timer0_irq : (sel == 1) ? gpio_irq : bandgap_on;
      if (s === 1'b1 && (sel < 2 || !p)) n++;
      p = s;
    end
    chk("event count", exp, n);
  endtask
  // pulse a reset source that should free a locked device
  task automatic kick(input int which);
    @(posedge clk);
    if (which == 0) watchdog_reset <= 1'b1;
    else external_reset_pin <= 1'b1;
    repeat (4) @(posedge clk);
    watchdog_reset <= 1'b0;
    external_reset_pin <= 1'b0;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // hang guard, far above the several hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      test_done;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 6; i++) rc(ra[i], rv[i]);
    // interrupt raise, mask, clear
    wr(8'h13, 8'h04);
    wr(8'h15, 8'h04);
    u_host.pulse(2);
    cnt(1, 20, 8'h01);
    rc(8'h14, 8'h04);
    chk_irq(1'b1);
    wr(8'h15, 8'h00);
    chk_irq(1'b0);
    wr(8'h15, 8'h04);
    chk_irq(1'b1);
    wr(8'h14, 8'h04);
    chk_irq(1'b0);
    rc(8'h14, 8'h00);
    // default refresh in standby, gpio wake
    wr(8'h13, 8'h04);
    wr(8'h12, 8'h03);
    wait_sl(1'b1);
    cnt(2, 4 * RP, 8'h04);
    u_host.pulse(2);
    wait_sl(1'b0);
    // doubled interval in host sleep locks on wake
    wr(8'h10, 8'h01);
    wr(8'h13, 8'h10);
    wr(8'h12, 8'h05);
    wait_sl(1'b1);
    cnt(2, 4 * RP, 8'h02);
    u_host.pulse(0);
    repeat (20) @(posedge clk);
    chk("locked", 8'h01, {7'h00, sleeping});
    kick(0);
    wait_sl(1'b0);
    // refresh disabled, lock cleared by the reset pin
    wr(8'h10, 8'h00);
    wr(8'h13, 8'h10);
    wr(8'h11, 8'h08);
    wr(8'h12, 8'h03);
    wait_sl(1'b1);
    cnt(2, 4 * RP, 8'h00);
    u_host.pulse(0);
    repeat (20) @(posedge clk);
    chk("locked", 8'h01, {7'h00, sleeping});
    kick(1);
    wait_sl(1'b0);
    wr(8'h11, 8'h00);
    wr(8'h14, 8'hFF);
    // gpio edge just ahead of the sleep command is lost
    wr(8'h13, 8'h0C);
    u_host.set(2, 1'b1);
    @(posedge clk);
    wr(8'h12, 8'h01);
    cnt(1, 20, 8'h00);
    u_host.set(1, 1'b1);
    wait_sl(1'b0);
    rc(8'h14, 8'h28);
    u_host.set(1, 1'b0);
    u_host.set(2, 1'b0);
    wr(8'h14, 8'hFF);
    // one-shot timer0 wake posts twice, then firmware clears the bit
    wr(8'h13, 8'h00);
    wr(8'h17, 8'h28);
    wr(8'hB0, 8'h03);
    wr(8'h12, 8'h01);
    cnt(0, 300, 8'h02);
    rc(8'hB0, 8'h02);
    wr(8'hB0, 8'h02 & 8'hFD);
    rc(8'hB0, 8'h00);
    test_done;
  end
endmodule
bind swc_top swc_monitor i_mon (.clk(clk), .reset_n(reset_n),
  .watchdog_reset(watchdog_reset), .external_reset_pin(external_reset_pin),
  .wake_pins(wake_pins), .bus_req(bus_req), .rdata(rdata), .irq(irq),
  .sleeping(sleeping), .bandgap_on(bandgap_on), .timer0_irq(timer0_irq),
  .gpio_irq(gpio_irq));
`default_nettype wire
